//--- hw/pmh_pkg.sv
// shared constants and types of the plc measurement handshake block
package pmh_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int VAL_W = 16;
  localparam int ADDR_W = 5;
  localparam int DUTY_W = 8;
  localparam int LIM_W = 20;
  localparam int NUM_LIM = 4;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_CMD = 5'h04;
  localparam logic [ADDR_W-1:0] REG_TARE_LIMIT = 5'h08;
  localparam logic [ADDR_W-1:0] REG_LIMIT0 = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_LIMIT3 = 5'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h1c;
  localparam logic [2:0] LIMIT_BASE_IDX = 3'h3;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_LOG_EN = 0;
  localparam int CTRL_TARE_WARN_EN = 1;
  localparam int CTRL_ACK_FN = 2;
  localparam int CTRL_ACK_PASS = 3;
  localparam int CTRL_ACK_FAIL = 4;
  localparam int CTRL_ONL1_EN = 5;
  localparam int CTRL_ONL2_EN = 6;
  localparam int CTRL_DUTY_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_8000;

  // ----------------------------------------------------------------
  // command register bits (write-only pulses)
  // ----------------------------------------------------------------
  localparam int CMD_EVAL_DONE = 0;
  localparam int CMD_PASS = 1;
  localparam int CMD_LOG_DONE = 2;
  localparam int CMD_TARE_DONE = 3;

  // ----------------------------------------------------------------
  // limit register fields
  // ----------------------------------------------------------------
  localparam int LIM_CH_Y = 16;
  localparam int LIM_TRIG = 17;
  localparam int LIM_ACT_LOW = 18;
  localparam int LIM_EN = 19;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PWM_STEP_NS = 40;
  localparam int PWM_STEP_CYCLES = (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // handshake phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_MEASURE,
    ST_EVAL,
    ST_ACK,
    ST_LOG,
    ST_ZERO
  } pmh_state_t;

endpackage

//--- hw/pmh_limit_bank.sv
// four limit switching outputs for channels x and y
`timescale 1ns/1ps
module pmh_limit_bank (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic signed [pmh_pkg::VAL_W-1:0] xValue,
  input wire logic signed [pmh_pkg::VAL_W-1:0] yValue,
  input wire logic signed [pmh_pkg::VAL_W-1:0] xAtTrigger,
  input wire logic triggered,
  input wire logic measuring,
  input wire logic [pmh_pkg::NUM_LIM-1:0][pmh_pkg::LIM_W-1:0] limitCfg,
  output logic [pmh_pkg::NUM_LIM-1:0] limitSwitch
);

  logic signed [pmh_pkg::VAL_W-1:0] xRelative;

  // wraps on overflow; range is left to the threshold setting
  assign xRelative = xValue - xAtTrigger;

  for (genvar i = 0; i < pmh_pkg::NUM_LIM; i++) begin : g_lim
    logic [pmh_pkg::LIM_W-1:0] cfg;
    logic signed [pmh_pkg::VAL_W-1:0] thr;
    logic signed [pmh_pkg::VAL_W-1:0] val;
    logic useTrig;
    logic actLow;
    assign cfg = limitCfg[i];
    assign thr = cfg[pmh_pkg::VAL_W-1:0];
    assign useTrig = cfg[pmh_pkg::LIM_TRIG] & ~cfg[pmh_pkg::LIM_CH_Y];
    assign actLow = cfg[pmh_pkg::LIM_ACT_LOW];
    always_comb begin
      if (cfg[pmh_pkg::LIM_CH_Y]) begin
        val = yValue;
      end else if (useTrig) begin
        val = xRelative;
      end else begin
        val = xValue;
      end
    end
    // no mode gating for absolute x and y limits; trigger x limits update only while measuring after the trigger
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        limitSwitch[i] <= 1'b0;
      end else if (!cfg[pmh_pkg::LIM_EN]) begin
        limitSwitch[i] <= actLow;
      end else if (!useTrig || (measuring && triggered)) begin
        limitSwitch[i] <= (val > thr) ^ actLow;
      end
    end
  end

endmodule

//--- hw/pmh_tone_flash.sv
// buzzer pwm and lamp flash timebase
`timescale 1ns/1ps
module pmh_tone_flash #(
  parameter int FLASH_HALF_CYCLES = pmh_pkg::FLASH_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pmh_pkg::DUTY_W-1:0] duty,
  output logic pwmOut,
  output logic flashPhase
);

  localparam int STEP_W = $clog2(pmh_pkg::PWM_STEP_CYCLES + 1);
  localparam int FLASH_W = $clog2(FLASH_HALF_CYCLES + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(pmh_pkg::PWM_STEP_CYCLES - 1);
  localparam logic [FLASH_W-1:0] FLASH_LAST = FLASH_W'(FLASH_HALF_CYCLES - 1);

  logic [STEP_W-1:0] stepCount;
  logic stepEn;
  logic [pmh_pkg::DUTY_W-1:0] ramp;
  logic [FLASH_W-1:0] flashCount;

  // ----------------------------------------------------------------
  // pwm carrier
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stepCount <= '0;
      stepEn <= 1'b0;
    end else begin
      stepEn <= (stepCount == STEP_LAST);
      stepCount <= (stepCount == STEP_LAST) ? '0 : stepCount + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ramp <= '0;
      pwmOut <= 1'b0;
    end else begin
      if (stepEn) begin
        ramp <= ramp + 1'b1;
      end
      pwmOut <= (ramp < duty);
    end
  end

  // ----------------------------------------------------------------
  // lamp flash
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flashCount <= '0;
      flashPhase <= 1'b1;
    end else if (flashCount == FLASH_LAST) begin
      flashCount <= '0;
      flashPhase <= ~flashPhase;
    end else begin
      flashCount <= flashCount + 1'b1;
    end
  end

endmodule

//--- hw/pmh_plc_measure_handshake.sv
// plc handshake: measurement, tare, online signals, limits, acknowledgement
`timescale 1ns/1ps
// Behaviour
// - logging holds standby low until transfer done
// - logging output rises at measurement start
// - measuring drives pass, fail high, standby low
// - verdict encoded as complementary pass/fail
// - standby returns high after evaluation
// - zero request drops standby until zeroing done
// - tare warning set when value exceeds limit
// - window infringement raises its online output
// - both online outputs cleared at measurement start
// - clean window transit leaves output low
// - absolute x and y limit outputs work in every mode
// - absolute x limit follows x both ways
// - absolute x measured from sensor zero
// - trigger x limit only after trigger, relative
// - y limit follows y both ways
// - lamps under the ack function enable; buzzer, lock, acknowledge with per-verdict enables
// - buzzer driven as pwm waveform
// - reject acknowledge: flash, lock, buzz until ack
// - fail lamp stays until next measurement
module pmh_plc_measure_handshake #(
  parameter int FLASH_HALF_CYCLES = pmh_pkg::FLASH_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pmh_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic measureRequest,
  input wire logic zeroRequestY1,
  input wire logic failAcknowledgeIn,
  input wire logic passAcknowledgeIn,
  input wire logic signed [pmh_pkg::VAL_W-1:0] xValue,
  input wire logic signed [pmh_pkg::VAL_W-1:0] yValue,
  input wire logic triggerEvent,
  input wire logic windowHit1,
  input wire logic windowHit2,
  output logic standbyIndicator,
  output logic passResult,
  output logic failResult,
  output logic hostLoggingActive,
  output logic zeroOffsetWarning,
  output logic windowViolation1,
  output logic windowViolation2,
  output logic [pmh_pkg::NUM_LIM-1:0] limitSwitch,
  output logic passLamp,
  output logic failLamp,
  output logic partLockOut,
  output logic alarmSounder
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pmh_pkg::pmh_state_t state;
  logic [31:0] ctrl;
  logic [pmh_pkg::VAL_W-1:0] tareLimit;
  logic [pmh_pkg::NUM_LIM-1:0][pmh_pkg::LIM_W-1:0] limitCfg;
  logic measSync1, measSync2, measPrev;
  logic zeroSync1, zeroSync2, zeroPrev;
  logic failAckSync1, failAckSync2;
  logic passAckSync1, passAckSync2;
  logic measRise, measFall, zeroRise;
  logic busWrite, busRead;
  logic cmdEvalDone, cmdPass, cmdLogDone, cmdTareDone;
  logic [2:0] limitIdx;
  logic isLimitAddr;
  logic verdictPass, verdictValid;
  logic needAck, ackSeen;
  logic triggered;
  logic signed [pmh_pkg::VAL_W-1:0] xAtTrigger;
  logic pwmOut, flashPhase;
  logic startMeas;
  logic [31:0] next_readdata;

  // ----------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      measSync1 <= 1'b0;
      measSync2 <= 1'b0;
      measPrev <= 1'b0;
      zeroSync1 <= 1'b0;
      zeroSync2 <= 1'b0;
      zeroPrev <= 1'b0;
      failAckSync1 <= 1'b0;
      failAckSync2 <= 1'b0;
      passAckSync1 <= 1'b0;
      passAckSync2 <= 1'b0;
    end else begin
      measSync1 <= measureRequest;
      measSync2 <= measSync1;
      measPrev <= measSync2;
      zeroSync1 <= zeroRequestY1;
      zeroSync2 <= zeroSync1;
      zeroPrev <= zeroSync2;
      failAckSync1 <= failAcknowledgeIn;
      failAckSync2 <= failAckSync1;
      passAckSync1 <= passAcknowledgeIn;
      passAckSync2 <= passAckSync1;
    end
  end

  assign measRise = measSync2 & ~measPrev;
  assign measFall = ~measSync2 & measPrev;
  assign zeroRise = zeroSync2 & ~zeroPrev;

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle per access
  // ----------------------------------------------------------------
  assign busWrite = write & ~waitrequest;
  assign busRead = read & ~waitrequest;
  assign limitIdx = address[4:2] - pmh_pkg::LIMIT_BASE_IDX;
  assign isLimitAddr = (address >= pmh_pkg::REG_LIMIT0) && (address <= pmh_pkg::REG_LIMIT3);
  assign cmdEvalDone = busWrite && address == pmh_pkg::REG_CMD
                       && writedata[pmh_pkg::CMD_EVAL_DONE];
  assign cmdPass = writedata[pmh_pkg::CMD_PASS];
  assign cmdLogDone = busWrite && address == pmh_pkg::REG_CMD
                      && writedata[pmh_pkg::CMD_LOG_DONE];
  assign cmdTareDone = busWrite && address == pmh_pkg::REG_CMD
                       && writedata[pmh_pkg::CMD_TARE_DONE];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= pmh_pkg::CTRL_RESET;
      tareLimit <= '0;
      limitCfg <= '0;
    end else if (busWrite) begin
      if (address == pmh_pkg::REG_CTRL) begin
        ctrl <= writedata;
      end else if (address == pmh_pkg::REG_TARE_LIMIT) begin
        tareLimit <= writedata[pmh_pkg::VAL_W-1:0];
      end else if (isLimitAddr) begin
        limitCfg[limitIdx[1:0]] <= writedata[pmh_pkg::LIM_W-1:0];
      end
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (address == pmh_pkg::REG_CTRL) begin
      next_readdata = ctrl;
    end else if (address == pmh_pkg::REG_TARE_LIMIT) begin
      next_readdata = {16'h0000, tareLimit};
    end else if (isLimitAddr) begin
      next_readdata = {12'h000, limitCfg[limitIdx[1:0]]};
    end else if (address == pmh_pkg::REG_STATUS) begin
      next_readdata = {12'h000, limitSwitch, 2'b00, 3'(state),
                       alarmSounder, partLockOut, failLamp, passLamp,
                       windowViolation2, windowViolation1, zeroOffsetWarning,
                       hostLoggingActive, failResult, passResult, standbyIndicator};
    end
  end

  // data loaded as waitrequest falls so it stands in the answer cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // handshake state machine
  // ----------------------------------------------------------------
  // measurement wins over zeroing if both rise together
  assign startMeas = (state == pmh_pkg::ST_STANDBY) && measRise;
  assign needAck = ctrl[pmh_pkg::CTRL_ACK_FN]
                   && (cmdPass ? ctrl[pmh_pkg::CTRL_ACK_PASS] : ctrl[pmh_pkg::CTRL_ACK_FAIL]);
  assign ackSeen = verdictPass ? passAckSync2 : failAckSync2;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= pmh_pkg::ST_STANDBY;
      standbyIndicator <= 1'b1;
      passResult <= 1'b0;
      failResult <= 1'b0;
      hostLoggingActive <= 1'b0;
      verdictPass <= 1'b0;
      verdictValid <= 1'b0;
    end else begin
      unique case (state)
        pmh_pkg::ST_STANDBY: begin
          if (measRise) begin
            state <= pmh_pkg::ST_MEASURE;
            standbyIndicator <= 1'b0;
            passResult <= 1'b1;
            failResult <= 1'b1;
            verdictValid <= 1'b0;
            hostLoggingActive <= ctrl[pmh_pkg::CTRL_LOG_EN];
          end else if (zeroRise) begin
            state <= pmh_pkg::ST_ZERO;
            standbyIndicator <= 1'b0;
          end
        end
        pmh_pkg::ST_MEASURE: begin
          if (measFall) begin
            state <= pmh_pkg::ST_EVAL;
          end
        end
        pmh_pkg::ST_EVAL: begin
          if (cmdEvalDone) begin
            passResult <= cmdPass;
            failResult <= ~cmdPass;
            verdictPass <= cmdPass;
            verdictValid <= 1'b1;
            if (needAck) begin
              state <= pmh_pkg::ST_ACK;
            end else if (hostLoggingActive) begin
              state <= pmh_pkg::ST_LOG;
            end else begin
              state <= pmh_pkg::ST_STANDBY;
              standbyIndicator <= 1'b1;
            end
          end
        end
        pmh_pkg::ST_ACK: begin
          if (ackSeen) begin
            if (hostLoggingActive) begin
              state <= pmh_pkg::ST_LOG;
            end else begin
              state <= pmh_pkg::ST_STANDBY;
              standbyIndicator <= 1'b1;
            end
          end
        end
        pmh_pkg::ST_LOG: begin
          // no timeout: the transfer may take as long as it needs
          if (cmdLogDone) begin
            state <= pmh_pkg::ST_STANDBY;
            standbyIndicator <= 1'b1;
            hostLoggingActive <= 1'b0;
          end
        end
        pmh_pkg::ST_ZERO: begin
          if (cmdTareDone) begin
            state <= pmh_pkg::ST_STANDBY;
            standbyIndicator <= 1'b1;
          end
        end
        default: begin
          state <= pmh_pkg::ST_STANDBY;
          standbyIndicator <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // tare warning
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      zeroOffsetWarning <= 1'b0;
    end else if (state == pmh_pkg::ST_STANDBY && zeroRise && !measRise) begin
      zeroOffsetWarning <= 1'b0;
    end else if (state == pmh_pkg::ST_ZERO && ctrl[pmh_pkg::CTRL_TARE_WARN_EN]
                 && yValue > $signed(tareLimit)) begin
      zeroOffsetWarning <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // window online signals
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      windowViolation1 <= 1'b0;
      windowViolation2 <= 1'b0;
    end else if (startMeas) begin
      windowViolation1 <= 1'b0;
      windowViolation2 <= 1'b0;
    end else if (state == pmh_pkg::ST_MEASURE) begin
      // only a reported infringement sets them
      if (windowHit1 && ctrl[pmh_pkg::CTRL_ONL1_EN]) begin
        windowViolation1 <= 1'b1;
      end
      if (windowHit2 && ctrl[pmh_pkg::CTRL_ONL2_EN]) begin
        windowViolation2 <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger capture for relative x limits
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      triggered <= 1'b0;
      xAtTrigger <= '0;
    end else if (startMeas) begin
      triggered <= 1'b0;
    end else if (state == pmh_pkg::ST_MEASURE && triggerEvent && !triggered) begin
      triggered <= 1'b1;
      xAtTrigger <= xValue;
    end
  end

  pmh_limit_bank u_limits (
    .ref_clk(ref_clk),
    .rst(rst),
    .xValue(xValue),
    .yValue(yValue),
    .xAtTrigger(xAtTrigger),
    .triggered(triggered),
    .measuring(state == pmh_pkg::ST_MEASURE),
    .limitCfg(limitCfg),
    .limitSwitch(limitSwitch)
  );

  // ----------------------------------------------------------------
  // acknowledgement lamps, lock and buzzer
  // ----------------------------------------------------------------
  pmh_tone_flash #(
    .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)
  ) u_tone (
    .ref_clk(ref_clk),
    .rst(rst),
    .duty(ctrl[pmh_pkg::CTRL_DUTY_LSB +: pmh_pkg::DUTY_W]),
    .pwmOut(pwmOut),
    .flashPhase(flashPhase)
  );

  // lamp verdict held until the next measurement clears verdictValid
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      passLamp <= 1'b0;
      failLamp <= 1'b0;
      partLockOut <= 1'b0;
      alarmSounder <= 1'b0;
    end else begin
      passLamp <= ctrl[pmh_pkg::CTRL_ACK_FN] && verdictValid && verdictPass
                  && (state != pmh_pkg::ST_ACK || flashPhase);
      failLamp <= ctrl[pmh_pkg::CTRL_ACK_FN] && verdictValid && !verdictPass
                  && (state != pmh_pkg::ST_ACK || flashPhase);
      partLockOut <= (state == pmh_pkg::ST_ACK) && !ackSeen;
      alarmSounder <= (state == pmh_pkg::ST_ACK) && !ackSeen && pwmOut;
    end
  end

endmodule

//--- verification/pmh_handshake_asserts.sv
// port checker of the plc measurement handshake block
`timescale 1ns/1ps
module pmh_handshake_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic measureRequest,
  input wire logic zeroRequestY1,
  input wire logic failAcknowledgeIn,
  input wire logic passAcknowledgeIn,
  input wire logic windowHit1,
  input wire logic standbyIndicator,
  input wire logic passResult,
  input wire logic failResult,
  input wire logic hostLoggingActive,
  input wire logic windowViolation1,
  input wire logic windowViolation2,
  input wire logic failLamp,
  input wire logic partLockOut,
  input wire logic alarmSounder
);
  // ----------------------------------------------------------------
  // handshake relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic measuring;
  assign measuring = passResult && failResult;
  a_meas_standby_low: assert property (measuring |-> !standbyIndicator)
    else $error("standby high while measuring");
  a_verdict_split: assert property ($fell(measuring) && !$past(rst) |-> passResult != failResult)
    else $error("verdict not complementary");
  a_log_holds_rdy: assert property (hostLoggingActive |-> !standbyIndicator)
    else $error("standby high during logging");
  a_start_clears_win: assert property ($rose(measuring) |-> !windowViolation1 && !windowViolation2)
    else $error("window flags kept at start");
  a_start_from_rdy: assert property ($rose(measuring) |-> $past(standbyIndicator))
    else $error("start outside standby");
  a_win_needs_hit: assert property ($rose(windowViolation1) |-> $past(windowHit1))
    else $error("window flag without hit");
  // sync delay of the pin is three edges, so six is a safe bound
  a_zero_drops_rdy: assert property ($rose(zeroRequestY1) && standbyIndicator && !measureRequest
    |-> ##[1:6] !standbyIndicator)
    else $error("zero request left standby high");
  a_ack_releases: assert property ((failAcknowledgeIn && passAcknowledgeIn) [*6] |-> !partLockOut)
    else $error("lock kept after acknowledge");
  a_buzz_with_lock: assert property (alarmSounder |-> partLockOut || $past(partLockOut))
    else $error("buzzer outside ack wait");
  // flashing while locked is legal, so only a fall after the wait counts
  a_lamp_holds: assert property ($fell(failLamp) && !$past(rst) && !$past(partLockOut)
    |-> measuring)
    else $error("fail lamp dropped before start");
  c_measure: cover property ($rose(measuring));
  c_ack: cover property ($fell(partLockOut));
  c_window: cover property ($rose(windowViolation1));
  c_logging: cover property ($rose(hostLoggingActive));
endmodule

bind pmh_plc_measure_handshake pmh_handshake_asserts i_asserts (.ref_clk, .rst, .measureRequest,
  .zeroRequestY1, .failAcknowledgeIn, .passAcknowledgeIn, .windowHit1, .standbyIndicator,
  .passResult, .failResult, .hostLoggingActive, .windowViolation1, .windowViolation2, .failLamp,
  .partLockOut, .alarmSounder);

//--- verification/pmh_plc_model.sv
// controller model driving the handshake pins
`timescale 1ns/1ps
module pmh_plc_model (
  input wire logic ref_clk,
  input wire logic standbyIndicator,
  output logic measureRequest,
  output logic zeroRequestY1,
  output logic failAcknowledgeIn,
  output logic passAcknowledgeIn,
  output logic err
);
  initial begin
    measureRequest = 1'h0;
    zeroRequestY1 = 1'h0;
    failAcknowledgeIn = 1'h0;
    passAcknowledgeIn = 1'h0;
    err = 1'h0;
  end
  // bounded, a stuck handshake raises err instead of hanging
  task automatic wait_rdy(input logic lvl);
    int n = 0;
    while (standbyIndicator !== lvl && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 2000) err <= 1'h1;
  endtask
  task automatic begin_measure();
    wait_rdy(1'h1);
    measureRequest <= 1'h1;
    wait_rdy(1'h0);
  endtask
  task automatic end_measure();
    measureRequest <= 1'h0;
  endtask
  task automatic zero();
    wait_rdy(1'h1);
    zeroRequestY1 <= 1'h1;
    wait_rdy(1'h0);
    zeroRequestY1 <= 1'h0;
  endtask
  task automatic ack();
    failAcknowledgeIn <= 1'h1;
    passAcknowledgeIn <= 1'h1;
    repeat (8) @(posedge ref_clk);
    failAcknowledgeIn <= 1'h0;
    passAcknowledgeIn <= 1'h0;
  endtask
endmodule

//--- verification/testbench.sv
// self-checking bench of the plc measurement handshake block
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] address = 5'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, measureRequest, zeroRequestY1, failAcknowledgeIn, passAcknowledgeIn, err;
  logic signed [15:0] xValue = 16'h0;
  logic signed [15:0] yValue = 16'h0;
  logic windowHit1 = 1'h0;
  logic triggerEvent = 1'h0;
  logic standbyIndicator, passResult, failResult, hostLoggingActive, zeroOffsetWarning;
  logic windowViolation1, windowViolation2, passLamp, failLamp, partLockOut, alarmSounder;
  logic [3:0] limitSwitch;
  int fails = 0;
  int totalChecks = 0;
  always #5 ref_clk = ~ref_clk;
  pmh_plc_model plc (.ref_clk, .standbyIndicator, .measureRequest, .zeroRequestY1,
    .failAcknowledgeIn, .passAcknowledgeIn, .err);
  // short flash period keeps the run small
  pmh_plc_measure_handshake #(.FLASH_HALF_CYCLES(16)) i_dut (.ref_clk, .rst, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .measureRequest, .zeroRequestY1,
    .failAcknowledgeIn, .passAcknowledgeIn, .xValue, .yValue, .triggerEvent, .windowHit1,
    .windowHit2(1'h0), .standbyIndicator, .passResult, .failResult, .hostLoggingActive,
    .zeroOffsetWarning, .windowViolation1, .windowViolation2, .limitSwitch, .passLamp, .failLamp,
    .partLockOut, .alarmSounder);
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 50);
    if (n == 50) begin
      fails++;
      finish_test();
    end
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge ref_clk);
  endtask
  initial begin
    cyc(100000);
    fails++;
    finish_test();
  end
  initial begin
    int n;
    cyc(20);
    rst <= 1'h0;
    cyc(2);
    bus(1'h0, pmh_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h1);
    bus(1'h0, pmh_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h8000);
    bus(1'h0, 5'h02, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    bus(1'h1, pmh_pkg::REG_CTRL, 32'h8035);
    plc.begin_measure();
    cyc(1);
    chk({passResult, failResult, standbyIndicator, hostLoggingActive}, 4'hd);
    windowHit1 <= 1'h1;
    cyc(1);
    windowHit1 <= 1'h0;
    cyc(2);
    chk({windowViolation1, windowViolation2}, 2'h2);
    plc.end_measure();
    cyc(6);
    bus(1'h1, pmh_pkg::REG_CMD, 32'h1);
    cyc(2);
    chk({passResult, failResult, partLockOut, standbyIndicator}, 4'h6);
    n = 0;
    while (alarmSounder !== 1'h1 && n < 1100) begin
      cyc(1);
      n++;
    end
    chk(alarmSounder, 1'h1);
    plc.ack();
    cyc(2);
    chk({partLockOut, alarmSounder, failLamp, standbyIndicator}, 4'h2);
    bus(1'h1, pmh_pkg::REG_CMD, 32'h4);
    cyc(2);
    chk({standbyIndicator, hostLoggingActive, failLamp}, 3'h5);
    $display("reject test done");
    // ack function kept on so the fail lamp must hold until the next start
    bus(1'h1, pmh_pkg::REG_CTRL, 32'h8004);
    plc.begin_measure();
    cyc(1);
    chk({windowViolation1, failLamp, hostLoggingActive}, 3'h0);
    plc.end_measure();
    cyc(6);
    plc.zeroRequestY1 <= 1'h1;
    cyc(4);
    bus(1'h1, pmh_pkg::REG_CMD, 32'h3);
    cyc(6);
    chk({passResult, failResult, standbyIndicator, passLamp}, 4'hb);
    plc.zeroRequestY1 <= 1'h0;
    cyc(4);
    $display("pass test done");
    bus(1'h1, pmh_pkg::REG_CTRL, 32'h8002);
    bus(1'h1, pmh_pkg::REG_TARE_LIMIT, 32'h10);
    yValue <= 16'h20;
    plc.zero();
    cyc(2);
    bus(1'h1, pmh_pkg::REG_CMD, 32'h8);
    cyc(2);
    chk({standbyIndicator, zeroOffsetWarning}, 2'h3);
    $display("zero test done");
    bus(1'h1, pmh_pkg::REG_LIMIT0, 32'h0008_0064);
    bus(1'h1, 5'h10, 32'h000d_0064);
    bus(1'h1, 5'h14, 32'h000a_0005);
    xValue <= 16'h65;
    yValue <= 16'h65;
    cyc(3);
    chk(limitSwitch, 4'h1);
    xValue <= 16'h10;
    yValue <= 16'h10;
    cyc(3);
    chk(limitSwitch, 4'h2);
    plc.begin_measure();
    triggerEvent <= 1'h1;
    cyc(1);
    triggerEvent <= 1'h0;
    xValue <= 16'h16;
    cyc(3);
    chk(limitSwitch, 4'h6);
    plc.end_measure();
    cyc(6);
    bus(1'h1, pmh_pkg::REG_CMD, 32'h1);
    cyc(2);
    chk({passResult, failResult, standbyIndicator}, 3'h3);
    chk(err, 1'h0);
    $display("limit test done");
    finish_test();
  end
endmodule
